// ===== bench/cstc_host.sv
`timescale 1ns/100ps
`default_nettype none

module cstc_host
  import cstc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [BUS_AW-1:0] adr,
  output logic [BUS_DW/8-1:0] sel,
  output logic [BUS_DW-1:0] dat,
  input wire logic [BUS_DW-1:0] rdat,
  input wire logic ack
);
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end

  // One classic cycle; only the bench watchdog ends a wait on a dead slave.
  task automatic xfer(input logic w, input logic [BUS_AW-1:0] a,
      input logic [BUS_DW-1:0] d, output logic [BUS_DW-1:0] q);
    @(posedge clock);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : xfer
endmodule : cstc_host

`default_nettype wire

// ===== bench/cstc_props.sv
`timescale 1ns/100ps
`default_nettype none

module cstc_props
  import cstc_pkg::*;
#(
  parameter int unsigned LEVEL_W = 16,
  parameter logic [LEVEL_W-1:0] LEVEL_MAX = 16'h0FFF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [BUS_AW-1:0] wb_adr_i,
  input wire logic [BUS_DW/8-1:0] wb_sel_i,
  input wire logic [BUS_DW-1:0] wb_dat_i,
  input wire logic [BUS_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Table engine and pins
  input wire logic seqValid,
  input wire logic [LEVEL_W-1:0] seqLevel,
  input wire logic currentLimitedPin,
  input wire logic triggerEventPin,
  // Outputs
  input wire logic [LEVEL_W-1:0] outputLevel,
  input wire logic outputOn,
  input wire logic frontReadoutEnable,
  input wire logic triggerArmed,
  input wire logic irq
);
  logic take;
  logic [3:0] limAge_reg, limAge_next, trigAge_reg, trigAge_next;

  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Saturating ages of each pin's last high level, so that a reaction
  // delayed by the pin filter can still be traced back to its cause.
  always_comb begin
    limAge_next = limAge_reg + {3'b000, limAge_reg != 4'hF};
    trigAge_next = trigAge_reg + {3'b000, trigAge_reg != 4'hF};
    if (currentLimitedPin) limAge_next = 4'h0;
    if (triggerEventPin) trigAge_next = 4'h0;
  end

  always_ff @(posedge clock) begin
    limAge_reg <= reset ? 4'hF : limAge_next;
    trigAge_reg <= reset ? 4'hF : trigAge_next;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge stood longer than one cycle.");
  a_ack_answer: assert property (take |=> wb_ack_o)
    else $error("Request was not answered in the next cycle.");
  a_reset_state: assert property ($past(reset) |->
      frontReadoutEnable && outputOn && !triggerArmed && outputLevel == '0)
    else $error("Outputs left reset with wrong values.");
  a_imm_write: assert property (take && wb_we_i &&
      wb_adr_i == OFS_IMM && wb_dat_i <= LEVEL_MAX
      |=> outputLevel == $past(wb_dat_i[LEVEL_W-1:0]))
    else $error("Immediate level write did not reach the output.");
  a_arm_cmd: assert property (take && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == OFS_CMD && wb_dat_i[2:0] == 3'b001 |=> triggerArmed)
    else $error("Arm command did not arm the trigger subsystem.");
  a_level_hold: assert property (!triggerArmed && !take &&
      !seqValid |=> $stable(outputLevel))
    else $error("Output level moved while the trigger was not armed.");
  a_trip_cause: assert property ($fell(outputOn) |->
      limAge_reg < 4'hA)
    else $error("Output switched off without current limiting.");
  a_readout_write: assert property ($changed(frontReadoutEnable) |->
      $past(take && wb_we_i && wb_adr_i == OFS_CTRL))
    else $error("Readout enable changed without a control write.");
  a_disarm_cause: assert property ($fell(triggerArmed) |->
      $past(take && wb_we_i) || $past(take && wb_we_i, 2) ||
      trigAge_reg < 4'hA)
    else $error("Trigger subsystem disarmed without a cause.");
endmodule : cstc_props

bind cstc_setpoint_ctrl cstc_props #(
  .LEVEL_W(LEVEL_W),
  .LEVEL_MAX(LEVEL_MAX)
) i_cstc_props (
  .clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .seqValid, .seqLevel,
  .currentLimitedPin, .triggerEventPin, .outputLevel, .outputOn,
  .frontReadoutEnable, .triggerArmed, .irq
);

`default_nettype wire

// ===== bench/tb_current_setpoint_trigger_control.sv
`timescale 1ns/100ps
`default_nettype none

module tb_current_setpoint_trigger_control
  import cstc_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cyc, stb, we, ack, outOn, readout, armed, irq;
  logic seqValid = 1'b0, limPin = 1'b0, trigPin = 1'b0;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic [15:0] seqLevel = '0, level;
  int errors = 0, checks = 0;

  always #12.5 clock = ~clock;

  cstc_host i_cstc_host (.clock(clock), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(dat), .rdat(rdat), .ack(ack));

  cstc_setpoint_ctrl i_cstc_setpoint_ctrl (.clock(clock), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .seqValid(seqValid), .seqLevel(seqLevel), .currentLimitedPin(limPin),
    .triggerEventPin(trigPin), .outputLevel(level), .outputOn(outOn),
    .frontReadoutEnable(readout), .triggerArmed(armed), .irq(irq));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_cstc_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_cstc_host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd

  task automatic seqStep(input logic [15:0] lv);
    seqValid <= 1'b1;
    seqLevel <= lv;
    tick(1);
    seqValid <= 1'b0;
    tick(1);
  endtask : seqStep

  // The pin filter delays the edge by several clocks, hence the tail.
  task automatic pulseTrig;
    trigPin <= 1'b1;
    tick(2);
    trigPin <= 1'b0;
    tick(8);
  endtask : pulseTrig

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_CTRL, 32'h0000_0002);
    rd(OFS_STAT, 32'h0000_0008);
    rd(OFS_IMM, 32'h0000_0000);
    rd(OFS_LIM_MAX, 32'h0000_0FFF);
    rd(OFS_LIM_MIN, 32'h0000_0000);
    wr(8'h40, 32'h0000_FFFF);
    rd(8'h40, 32'h0000_0000);
    chk(readout, 1'b1);
  endtask : t_reset

  task automatic t_table;
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_PEND, 32'h0000_0300);
    seqStep(16'h0055);
    chk(level, 16'h0000);
    wr(OFS_CTRL, 32'h0000_000A);
    rd(OFS_STAT, 32'h0000_0008);
    seqStep(16'h0055);
    chk(level, 16'h0055);
    wr(OFS_IMM, 32'h0000_0123);
    chk(level, 16'h0123);
    rd(OFS_IMM, 32'h0000_0123);
    wr(OFS_IMM, 32'h0001_2345);
    rd(OFS_IMM, 32'h0000_0FFF);
    wr(OFS_CTRL, 32'h0000_0002);
  endtask : t_table

  task automatic t_pend;
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_PEND, 32'h0000_0300);
    wr(OFS_IMM, 32'h0000_0100);
    rd(OFS_PEND, 32'h0000_0300);
    chk(level, 16'h0100);
    pulseTrig();
    chk(level, 16'h0300);
    chk(armed, 1'b0);
    rd(OFS_PEND, 32'h0000_0300);
    wr(OFS_PEND, 32'h0000_0400);
    pulseTrig();
    wr(OFS_CMD, 32'h0000_0004);
    tick(2);
    chk(level, 16'h0300);
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0002);
    rd(OFS_STAT, 32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_0006);
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_PEND, 32'h0000_0500);
    wr(OFS_CMD, 32'h0000_0004);
    tick(2);
    chk(level, 16'h0500);
    chk(armed, 1'b1);
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_CMD, 32'h0000_0002);
  endtask : t_pend

  task automatic t_oc;
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0003);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0003);
    chk(irq, 1'b0);
    limPin <= 1'b1;
    tick(10);
    chk(outOn, 1'b0);
    chk(irq, 1'b1);
    rd(OFS_STAT, 32'h0000_0004);
    limPin <= 1'b0;
    tick(8);
    wr(OFS_CMD, 32'h0000_0008);
    rd(OFS_STAT, 32'h0000_0008);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    tick(2);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    rd(OFS_IRQ_STAT, 32'h0000_0002);
    chk(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h0000_0003);
    tick(2);
    chk(irq, 1'b0);
    wr(OFS_CTRL, 32'h0000_0000);
    chk(readout, 1'b0);
  endtask : t_oc

  // Reset in mid-run, after the enables were moved off their defaults.
  task automatic t_rerun;
    wr(OFS_CTRL, 32'h0000_0005);
    chk(armed, 1'b1);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(2);
    chk(armed, 1'b0);
    chk(readout, 1'b1);
    rd(OFS_CTRL, 32'h0000_0002);
    rd(OFS_STAT, 32'h0000_0008);
  endtask : t_rerun

  task automatic complete_run;
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  end

  initial begin
    tick(8);
    t_reset();
    t_table();
    t_pend();
    t_oc();
    t_rerun();
    complete_run();
  end

  initial begin
    tick(20000);
    errors++;
    complete_run();
  end
endmodule : tb_current_setpoint_trigger_control

`default_nettype wire

// ===== hdl/cstc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module cstc_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Asynchronous pins and their filtered copies
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  // -----------------------------------------------------------------------
  // Three stages per bit
  // -----------------------------------------------------------------------
  // The first stage feeds only the second; a change is taken once the
  // second and third stages agree, which rejects one-cycle glitches.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gBit
      logic s1Reg, s2Reg, s3Reg, outReg;
      logic outNext;
      always_comb begin
        outNext = (s2Reg == s3Reg) ? s3Reg : outReg;
      end
      always_ff @(posedge clock) begin
        if (reset) begin
          s1Reg <= 1'b0;
          s2Reg <= 1'b0;
          s3Reg <= 1'b0;
          outReg <= 1'b0;
        end else begin
          s1Reg <= pinIn[g];
          s2Reg <= s1Reg;
          s3Reg <= s2Reg;
          outReg <= outNext;
        end
      end
      assign pinOut[g] = outReg;
    end
  endgenerate

endmodule : cstc_pin_sync

`default_nettype wire

// ===== hdl/cstc_pkg.sv
package cstc_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int unsigned BUS_DW = 32;
  localparam int unsigned BUS_AW = 8;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IMM = 8'h04;
  localparam logic [7:0] OFS_PEND = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_LIM_MAX = 8'h14;
  localparam logic [7:0] OFS_LIM_MIN = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CMD_ARM = 0;
  localparam int unsigned CMD_ABORT = 1;
  localparam int unsigned CMD_TRIG = 2;
  localparam int unsigned CMD_PCLR = 3;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_TRIG = 0;
  localparam int unsigned IRQ_OC = 1;

  // ---------------------------------------------------------------------
  // Control word, reset value and status word
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic seqMode;
    logic autoRearm;
    logic readoutOn;
    logic protectOn;
  } cstc_ctrl_t;

  localparam cstc_ctrl_t CTRL_RESET = '{
    seqMode: 1'b0, autoRearm: 1'b0, readoutOn: 1'b1, protectOn: 1'b0
  };

  typedef struct packed {
    logic outputOn;
    logic overcurrentFlag;
    logic pendingValid;
    logic armed;
  } cstc_status_t;

  // Pins from the power stage, carried together through the synchroniser.
  typedef struct packed {
    logic triggerEvent;
    logic currentLimited;
  } cstc_pins_t;

endpackage : cstc_pkg

// ===== hdl/cstc_setpoint_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module cstc_setpoint_ctrl
  import cstc_pkg::*;
#(
  parameter int unsigned LEVEL_W = 16,
  parameter logic [LEVEL_W-1:0] LEVEL_MAX = 16'h0FFF,
  parameter logic [LEVEL_W-1:0] LEVEL_MIN = 16'h0000,
  parameter logic [LEVEL_W-1:0] LEVEL_RESET = 16'h0000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [BUS_AW-1:0] wb_adr_i,
  input wire logic [BUS_DW/8-1:0] wb_sel_i,
  input wire logic [BUS_DW-1:0] wb_dat_i,
  output logic [BUS_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Sequenced table engine, same clock
  input wire logic seqValid,
  input wire logic [LEVEL_W-1:0] seqLevel,
  // Pins from the power stage
  input wire logic currentLimitedPin,
  input wire logic triggerEventPin,
  // Outputs to the power stage and front panel
  output logic [LEVEL_W-1:0] outputLevel,
  output logic outputOn,
  output logic frontReadoutEnable,
  output logic triggerArmed,
  output logic irq
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  cstc_pins_t pinsRaw;
  cstc_pins_t pinsSync;
  logic trigPinPrevReg;
  logic trigPinPrevNext;
  logic trigEdge;

  cstc_ctrl_t ctrlReg, ctrlNext;
  logic [LEVEL_W-1:0] immReg, immNext;
  logic [LEVEL_W-1:0] pendReg, pendNext;
  logic pendValidReg, pendValidNext;
  logic armedReg, armedNext;
  logic ocFlagReg, ocFlagNext;
  logic outOnReg, outOnNext;
  logic readoutReg, readoutNext;

  logic ackReg, ackNext;
  logic [BUS_DW-1:0] datReg, datNext;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic [BUS_DW-1:0] wrData;
  logic wrLow;

  logic cmdArm, cmdAbort, cmdTrig, cmdPclr;
  logic enterSeq;
  logic doAbort;
  logic fire;
  cstc_status_t status;

  logic [IRQ_W-1:0] irqStatReg, irqStatNext;
  logic [IRQ_W-1:0] irqMaskReg, irqMaskNext;
  logic irqReg, irqNext;
  logic [IRQ_W-1:0] irqEvents;
  logic [IRQ_W-1:0] irqClear;
  logic ocSet;

  // -----------------------------------------------------------------------
  // Level helpers
  // -----------------------------------------------------------------------
  // Bus-written values are held inside the programmable range; levels from
  // the table engine are taken unclamped, so a read can report one outside it.
  function automatic logic [LEVEL_W-1:0] clampLevel(
    input logic [BUS_DW-1:0] value
  );
    logic [LEVEL_W-1:0] lvl;
    lvl = value[LEVEL_W-1:0];
    if (value[BUS_DW-1:LEVEL_W] != '0 || lvl > LEVEL_MAX) begin
      lvl = LEVEL_MAX;
    end else if (lvl < LEVEL_MIN) begin
      lvl = LEVEL_MIN;
    end
    return lvl;
  endfunction : clampLevel

  function automatic logic [BUS_DW-1:0] widen(input logic [LEVEL_W-1:0] v);
    logic [BUS_DW-1:0] w;
    w = '0;
    w[LEVEL_W-1:0] = v;
    return w;
  endfunction : widen

  // -----------------------------------------------------------------------
  // Pin synchronisation
  // -----------------------------------------------------------------------
  assign pinsRaw.triggerEvent = triggerEventPin;
  assign pinsRaw.currentLimited = currentLimitedPin;

  cstc_pin_sync #(
    .WIDTH($bits(cstc_pins_t))
  ) uPinSync (
    .clock(clock),
    .reset(reset),
    .pinIn(pinsRaw),
    .pinOut(pinsSync)
  );

  // The previous level resets low, the idle level of the pin, so that no
  // false trigger edge follows a reset.
  always_comb begin
    trigPinPrevNext = pinsSync.triggerEvent;
    trigEdge = pinsSync.triggerEvent & ~trigPinPrevReg;
  end

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  // Every access is answered in the cycle after it is seen, mapped or not;
  // the write lands on that same edge, before the master sees the answer.
  always_comb begin
    access = wb_cyc_i & wb_stb_i & ~ackReg;
    wrAccess = access & wb_we_i;
    rdAccess = access & ~wb_we_i;
    wrData = wb_dat_i;
    wrLow = wb_sel_i[0];
    cmdArm = wrAccess && wb_adr_i == OFS_CMD && wrLow
             && wrData[CMD_ARM];
    cmdAbort = wrAccess && wb_adr_i == OFS_CMD && wrLow
               && wrData[CMD_ABORT];
    cmdTrig = wrAccess && wb_adr_i == OFS_CMD && wrLow
              && wrData[CMD_TRIG];
    cmdPclr = wrAccess && wb_adr_i == OFS_CMD && wrLow
              && wrData[CMD_PCLR];
  end

  // -----------------------------------------------------------------------
  // Setpoint, trigger and protection state
  // -----------------------------------------------------------------------
  always_comb begin
    ctrlNext = ctrlReg;
    immNext = immReg;
    pendNext = pendReg;
    pendValidNext = pendValidReg;
    armedNext = armedReg;
    ocFlagNext = ocFlagReg;
    enterSeq = 1'b0;

    // Control word; only the low CTRL_W bits are kept, one per enable, so the upper bits read as zero.
    // Only a change into sequenced mode aborts, so that rewriting the other
    // enables later leaves an armed trigger alone.
    if (wrAccess && wb_adr_i == OFS_CTRL && wrLow) begin
      ctrlNext = cstc_ctrl_t'(wrData[CTRL_W-1:0]);
      enterSeq = wrData[CTRL_W-1] & ~ctrlReg.seqMode;
    end

    doAbort = cmdAbort | enterSeq;
    // A trigger acts only while armed.
    fire = armedReg & (trigEdge | cmdTrig) & ~doAbort;

    // Table engine drives the output only in sequenced mode.
    if (ctrlReg.seqMode && seqValid) begin
      immNext = seqLevel;
    end
    // Trigger transfer of the pending level.
    if (fire && pendValidReg) begin
      immNext = pendReg;
    end
    // A direct write always wins and acts at once in either mode.
    if (wrAccess && wb_adr_i == OFS_IMM) begin
      immNext = clampLevel(wrData);
    end

    // Pending level lives until a trigger or an abort.
    if (fire || doAbort) begin
      pendValidNext = 1'b0;
    end
    if (wrAccess && wb_adr_i == OFS_PEND) begin
      pendNext = clampLevel(wrData);
      pendValidNext = 1'b1;
    end

    // Arming: one action per arm unless auto re-arm holds it on.
    // An abort outranks an arm in the same write; auto re-arm outranks both
    // and keeps the subsystem armed even through an abort.
    if (ctrlNext.autoRearm) begin
      armedNext = 1'b1;
    end else if (doAbort) begin
      armedNext = 1'b0;
    end else if (cmdArm) begin
      armedNext = 1'b1;
    end else if (fire) begin
      armedNext = 1'b0;
    end

    // Overcurrent latch; a trip in the clear cycle still sets it.
    ocSet = ctrlReg.protectOn & pinsSync.currentLimited & outOnReg;
    if (ocSet) begin
      ocFlagNext = 1'b1;
    end else if (cmdPclr) begin
      ocFlagNext = 1'b0;
    end
  end

  // The output follows the latch on the same edge, so it stays off for as
  // long as the overcurrent condition is latched.
  always_comb begin
    outOnNext = ~ocFlagNext;
    readoutNext = ctrlNext.readoutOn;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlReg <= CTRL_RESET;
      immReg <= LEVEL_RESET;
      pendReg <= LEVEL_RESET;
      pendValidReg <= 1'b0;
      armedReg <= 1'b0;
      ocFlagReg <= 1'b0;
      outOnReg <= 1'b1;
      readoutReg <= CTRL_RESET.readoutOn;
      trigPinPrevReg <= 1'b0;
    end else begin
      ctrlReg <= ctrlNext;
      immReg <= immNext;
      pendReg <= pendNext;
      pendValidReg <= pendValidNext;
      armedReg <= armedNext;
      ocFlagReg <= ocFlagNext;
      outOnReg <= outOnNext;
      readoutReg <= readoutNext;
      trigPinPrevReg <= trigPinPrevNext;
    end
  end

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  always_comb begin
    status.outputOn = outOnReg;
    status.overcurrentFlag = ocFlagReg;
    status.pendingValid = pendValidReg;
    status.armed = armedReg;
    ackNext = access;
    datNext = '0;
    if (rdAccess) begin
      case (wb_adr_i)
        OFS_CTRL: datNext = widen(LEVEL_W'(ctrlReg));
        OFS_IMM: datNext = widen(immReg);
        OFS_PEND: datNext = pendValidReg ? widen(pendReg)
                                         : widen(immReg);
        OFS_STAT: datNext = widen(LEVEL_W'(status));
        OFS_LIM_MAX: datNext = widen(LEVEL_MAX);
        OFS_LIM_MIN: datNext = widen(LEVEL_MIN);
        OFS_IRQ_STAT: datNext = widen(LEVEL_W'(irqStatReg));
        OFS_IRQ_MASK: datNext = widen(LEVEL_W'(irqMaskReg));
        default: datNext = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ackReg <= 1'b0;
      datReg <= '0;
    end else begin
      ackReg <= ackNext;
      datReg <= datNext;
    end
  end

  // -----------------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------------
  // Sticky bits, cleared by writing one; a new event beats the clear.
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_TRIG] = fire;
    irqEvents[IRQ_OC] = ocSet & ~ocFlagReg;
    irqClear = '0;
    irqMaskNext = irqMaskReg;
    if (wrAccess && wb_adr_i == OFS_IRQ_STAT && wrLow) begin
      irqClear = wrData[IRQ_W-1:0];
    end
    if (wrAccess && wb_adr_i == OFS_IRQ_MASK && wrLow) begin
      irqMaskNext = wrData[IRQ_W-1:0];
    end
    irqStatNext = (irqStatReg & ~irqClear) | irqEvents;
    irqNext = |(irqStatNext & irqMaskNext);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irqStatReg <= '0;
      irqMaskReg <= '0;
      irqReg <= 1'b0;
    end else begin
      irqStatReg <= irqStatNext;
      irqMaskReg <= irqMaskNext;
      irqReg <= irqNext;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;
  assign outputLevel = immReg;
  assign outputOn = outOnReg;
  assign frontReadoutEnable = readoutReg;
  assign triggerArmed = armedReg;
  assign irq = irqReg;

endmodule : cstc_setpoint_ctrl

`default_nettype wire
